// ### verilog/flash_row_pkg.sv
package flash_row_pkg;
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0]  OFS_CONTROL   = 8'h00;
   localparam logic [7:0]  OFS_KEY       = 8'h10;
   localparam logic [7:0]  OFS_TARGET    = 8'h20;
   localparam logic [7:0]  OFS_SOURCE    = 8'h40;
   localparam logic [7:0]  OFS_BOOTPROT  = 8'h90;
   localparam logic [7:0]  OFS_STATUS    = 8'hA0;
   // ****************************************
   // Base addresses per device group
   // ****************************************
   localparam logic [31:0] BASE_GROUP_A  = 32'hBF80_F400;
   localparam logic [31:0] BASE_GROUP_B  = 32'hBF80_0600;
   // ****************************************
   // Control fields and values
   // ****************************************
   localparam int          START_POS     = 15;
   localparam int          WRITE_ENABLE_BIT_POS      = 14;
   localparam logic [3:0]  OP_WORD       = 4'h1;
   localparam logic [3:0]  OP_QUAD       = 4'h2;
   localparam logic [3:0]  OP_ROW        = 4'h3;
   localparam logic [31:0] CTRL_ROW_SEL  = 32'h0000_4003;
   localparam logic [31:0] CTRL_START    = 32'h0000_8000;
   localparam logic [31:0] KEY_FIRST     = 32'hAA99_6655;
   localparam logic [31:0] KEY_SECOND    = 32'h5566_99AA;
   localparam logic [31:0] BOOT_UNPROT   = 32'h0000_8080;
   localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
   localparam logic [31:0] BOOTPROT_RST  = 32'h0000_0000;
   // ****************************************
   // Timing
   // ****************************************
   localparam int          WRITE_NS      = 400;
   localparam int          CLK_NS        = 4;
   localparam logic [15:0] WRITE_CYCLES  = 16'((WRITE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [7:0]  ROW_WORDS     = 8'h20;
endpackage

// ### verilog/flash_row_if.sv
`timescale 1ns/1ps
interface flash_row_if;
   logic [31:0] adr;
   logic [31:0] datW;
   logic [31:0] datR;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [3:0]  sel;
   logic        ack;
   modport device (input adr, datW, cyc, stb, we, sel, output datR, ack);
   modport host   (output adr, datW, cyc, stb, we, sel, input datR, ack);
endinterface

// ### verilog/flash_row_device.sv
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
// Overview of operation
// - ECC writes use aligned four-word groups
// - Single-word writes store no check bits
// - Quad and row writes store check bits
// - Host stages whole row in SRAM first
// - Executive mode writes row at once
// - Start bit 15 launches selected operation
// - Row select 0x4003, then start 0x8000
// - Two ordered key words unlock operation
// - 0x8080 at 144 clears boot protection
// - Register base depends on device group
// - Target row address at offset 32
// - SRAM source address at offset 64
// - Host pushes instructions until sequence ends
module flash_row_device (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Strap and mode
   input  wire logic        groupB,
   input  wire logic        execMode,
   input  wire logic        execGo,
   // Register port
   flash_row_if.device      bus,
   // Flash engine outputs
   output logic             flashBusy,
   output logic [31:0]      flashAddr,
   output logic [31:0]      sramAddr,
   output logic [3:0]       flashOp,
   output logic             eccStore,
   output logic             writeDone,
   output logic             alignErr
);
   // ****************************************
   // Registers
   // ****************************************
   logic [31:0] ctrl_q;
   logic [31:0] target_q;
   logic [31:0] source_q;
   logic [31:0] bootProt_q;
   logic [1:0]  keyState_q;
   logic        unlocked_q;
   logic [15:0] count_q;
   logic        ack_q;
   logic [31:0] datR_q;
   logic        groupB_q;
   logic        access;
   logic        hit;
   logic [7:0]  ofs;
   logic [31:0] base;

   function automatic logic ecc_op(input logic [3:0] op);
      ecc_op = (op == flash_row_pkg::OP_QUAD) || (op == flash_row_pkg::OP_ROW);
   endfunction

   // Group strap registered on every clock, reset or not
   always_ff @(posedge clk) begin
      groupB_q <= groupB;
   end

   assign base   = groupB_q ? flash_row_pkg::BASE_GROUP_B : flash_row_pkg::BASE_GROUP_A;
   assign hit    = (bus.adr[31:8] == base[31:8]) && (bus.adr[7:0] >= base[7:0]);
   assign ofs    = 8'(bus.adr[7:0] - base[7:0]);
   assign access = bus.cyc && bus.stb && !ack_q;

   // ****************************************
   // Bus answer, one wait cycle
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q  <= 1'b0;
         datR_q <= 32'h0000_0000;
      end else begin
         ack_q <= access;
         if (access && !bus.we) begin
            if (!hit) begin
               datR_q <= 32'h0000_0000;
            end else begin
               case (ofs)
                  flash_row_pkg::OFS_CONTROL:  datR_q <= ctrl_q;
                  flash_row_pkg::OFS_TARGET:   datR_q <= target_q;
                  flash_row_pkg::OFS_SOURCE:   datR_q <= source_q;
                  flash_row_pkg::OFS_BOOTPROT: datR_q <= bootProt_q;
                  flash_row_pkg::OFS_STATUS:
                     datR_q <= {28'h0, alignErr, unlocked_q, writeDone, flashBusy};
                  default:                     datR_q <= 32'h0000_0000;
               endcase
            end
         end
      end
   end
   assign bus.ack  = ack_q;
   assign bus.datR = datR_q;

   // ****************************************
   // Key sequence
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         keyState_q <= 2'd0;
         unlocked_q <= 1'b0;
      end else if (access && bus.we && hit) begin
         if (ofs == flash_row_pkg::OFS_KEY) begin
            if (bus.datW == flash_row_pkg::KEY_FIRST) begin
               keyState_q <= 2'd1;
            end else if (keyState_q == 2'd1 && bus.datW == flash_row_pkg::KEY_SECOND) begin
               keyState_q <= 2'd0;
               unlocked_q <= 1'b1;
            end else begin
               keyState_q <= 2'd0;
            end
         end else if (ofs == flash_row_pkg::OFS_CONTROL && bus.datW[flash_row_pkg::START_POS]) begin
            unlocked_q <= 1'b0; // Key consumed by start
         end else if (ofs != flash_row_pkg::OFS_BOOTPROT) begin
            keyState_q <= 2'd0;
         end
      end
   end

   // ****************************************
   // Address and protection registers
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         target_q   <= flash_row_pkg::RESET_VALUE;
         source_q   <= flash_row_pkg::RESET_VALUE;
         bootProt_q <= flash_row_pkg::BOOTPROT_RST;
      end else if (access && bus.we && hit && !flashBusy) begin
         if (ofs == flash_row_pkg::OFS_TARGET) begin
            target_q <= bus.datW;
         end
         if (ofs == flash_row_pkg::OFS_SOURCE) begin
            source_q <= bus.datW;
         end
         if (ofs == flash_row_pkg::OFS_BOOTPROT && unlocked_q && groupB_q) begin
            bootProt_q <= bus.datW & ~flash_row_pkg::BOOT_UNPROT;
         end
      end
   end

   // ****************************************
   // Control and write engine
   // ****************************************
   logic startReq;
   logic execReq;
   assign startReq = access && bus.we && hit && (ofs == flash_row_pkg::OFS_CONTROL)
                     && bus.datW[flash_row_pkg::START_POS] && ctrl_q[flash_row_pkg::WRITE_ENABLE_BIT_POS]
                     && unlocked_q && !flashBusy;
   assign execReq  = execMode && execGo && !flashBusy;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q    <= flash_row_pkg::RESET_VALUE;
         flashBusy <= 1'b0;
         count_q   <= 16'h0000;
         writeDone <= 1'b0;
         flashAddr <= 32'h0000_0000;
         sramAddr  <= 32'h0000_0000;
         flashOp   <= 4'h0;
         eccStore  <= 1'b0;
         alignErr  <= 1'b0;
      end else begin
         writeDone <= 1'b0;
         if (startReq || execReq) begin
            flashBusy <= 1'b1;
            count_q   <= flash_row_pkg::WRITE_CYCLES;
            flashAddr <= target_q;
            sramAddr  <= source_q;
            flashOp   <= execReq ? flash_row_pkg::OP_ROW : ctrl_q[3:0];
            eccStore  <= execReq ? 1'b1 : ecc_op(ctrl_q[3:0]);
            alignErr  <= (execReq || ecc_op(ctrl_q[3:0])) && (target_q[3:0] != 4'h0);
            ctrl_q[flash_row_pkg::START_POS] <= 1'b1;
         end else if (flashBusy) begin
            if (count_q == 16'h0001) begin
               flashBusy <= 1'b0;
               writeDone <= 1'b1;
               ctrl_q[flash_row_pkg::START_POS] <= 1'b0;
            end
            count_q <= 16'(count_q - 16'h0001);
         end else if (access && bus.we && hit && ofs == flash_row_pkg::OFS_CONTROL) begin
            ctrl_q <= bus.datW & 32'h0000_7FFF;
         end
      end
   end
endmodule

// ### verilog/flash_row_host.sv
`timescale 1ns/1ps
module flash_row_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // User request
   input  wire logic        go,
   input  wire logic        groupB,
   input  wire logic [31:0] rowAddr,
   input  wire logic [31:0] ramAddr,
   output logic             busy,
   output logic             done,
   // Register port
   flash_row_if.host        bus
);
   // ****************************************
   // Sequence of register accesses
   // ****************************************
   typedef enum {S_IDLE, S_KEY1, S_KEY2, S_BOOT, S_TGT, S_SRC, S_SEL, S_KEY3, S_KEY4,
                 S_GO, S_POLL, S_GAP} state_t;
   state_t      state_q;
   state_t      next_q;
   logic [31:0] base;
   logic [31:0] rowAddr_q;
   logic [31:0] ramAddr_q;
   logic        groupB_q;

   assign base = groupB_q ? flash_row_pkg::BASE_GROUP_B : flash_row_pkg::BASE_GROUP_A;
   assign busy = (state_q != S_IDLE);

   task automatic issue(input logic [7:0] ofs, input logic wr, input logic [31:0] d);
      bus.cyc  <= 1'b1;
      bus.stb  <= 1'b1;
      bus.we   <= wr;
      bus.sel  <= 4'hF;
      bus.adr  <= base + {24'h0, ofs};
      bus.datW <= d;
   endtask

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q   <= S_IDLE;
         next_q    <= S_IDLE;
         bus.cyc   <= 1'b0;
         bus.stb   <= 1'b0;
         bus.we    <= 1'b0;
         bus.sel   <= 4'h0;
         bus.adr   <= 32'h0000_0000;
         bus.datW  <= 32'h0000_0000;
         done      <= 1'b0;
         rowAddr_q <= 32'h0000_0000;
         ramAddr_q <= 32'h0000_0000;
         groupB_q  <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state_q)
            S_IDLE: if (go) begin
               rowAddr_q <= rowAddr;
               ramAddr_q <= ramAddr;
               groupB_q  <= groupB;
               state_q   <= groupB ? S_KEY1 : S_TGT;
            end
            S_GAP: state_q <= next_q;
            default: begin
               if (!bus.cyc) begin
                  case (state_q)
                     S_KEY1: issue(flash_row_pkg::OFS_KEY, 1'b1, flash_row_pkg::KEY_FIRST);
                     S_KEY2: issue(flash_row_pkg::OFS_KEY, 1'b1, flash_row_pkg::KEY_SECOND);
                     S_BOOT: issue(flash_row_pkg::OFS_BOOTPROT, 1'b1,
                                   flash_row_pkg::BOOT_UNPROT);
                     S_TGT:  issue(flash_row_pkg::OFS_TARGET, 1'b1, rowAddr_q);
                     S_SRC:  issue(flash_row_pkg::OFS_SOURCE, 1'b1, ramAddr_q);
                     S_SEL:  issue(flash_row_pkg::OFS_CONTROL, 1'b1,
                                   flash_row_pkg::CTRL_ROW_SEL);
                     S_KEY3: issue(flash_row_pkg::OFS_KEY, 1'b1, flash_row_pkg::KEY_FIRST);
                     S_KEY4: issue(flash_row_pkg::OFS_KEY, 1'b1, flash_row_pkg::KEY_SECOND);
                     S_GO:   issue(flash_row_pkg::OFS_CONTROL, 1'b1,
                                   flash_row_pkg::CTRL_START);
                     default: issue(flash_row_pkg::OFS_CONTROL, 1'b0, 32'h0000_0000);
                  endcase
               end else if (bus.ack) begin
                  bus.cyc <= 1'b0;
                  bus.stb <= 1'b0;
                  state_q <= S_GAP;
                  case (state_q)
                     S_KEY1: next_q <= S_KEY2;
                     S_KEY2: next_q <= S_BOOT;
                     S_BOOT: next_q <= S_TGT;
                     S_TGT:  next_q <= S_SRC;
                     S_SRC:  next_q <= S_SEL;
                     S_SEL:  next_q <= S_KEY3;
                     S_KEY3: next_q <= S_KEY4;
                     S_KEY4: next_q <= S_GO;
                     S_GO:   next_q <= S_POLL;
                     default: begin
                        // Poll until hardware clears start
                        if (!bus.datR[flash_row_pkg::START_POS]) begin
                           next_q <= S_IDLE;
                           done   <= 1'b1;
                        end else begin
                           next_q <= S_POLL;
                        end
                     end
                  endcase
               end
            end
         endcase
      end
   end
endmodule

// ### dv/flash_row_monitor.sv
`timescale 1ns/1ps
module flash_row_monitor (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // Bus
   input wire logic [31:0] adr,
   input wire logic [31:0] datW,
   input wire logic        cyc,
   input wire logic        stb,
   input wire logic        we,
   input wire logic        ack
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_req;
      cyc && stb && !ack;
   endsequence
   sequence s_wr(a, d);
      cyc && stb && we && ack && adr[7:0] == a && datW == d;
   endsequence
   property p_ack_one; s_req |=> ack; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack not one cycle late");
   property p_ack_drop; ack |=> !ack; endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("ack held");
   property p_hold; s_req |=> $stable(adr) && $stable(we) && $stable(datW); endproperty
   a_hold: assert property (p_hold) else $error("request changed");
   property p_release; ack |=> !stb && !cyc; endproperty
   a_release: assert property (p_release) else $error("no gap");
   property p_key;
      s_wr(flash_row_pkg::OFS_KEY, flash_row_pkg::KEY_FIRST)
         |-> ##[2:8] s_wr(flash_row_pkg::OFS_KEY, flash_row_pkg::KEY_SECOND);
   endproperty
   a_key: assert property (p_key) else $error("key order");
   property p_start;
      cyc && stb && we && adr[7:0] == flash_row_pkg::OFS_CONTROL
         |-> datW == flash_row_pkg::CTRL_START || datW == flash_row_pkg::CTRL_ROW_SEL;
   endproperty
   a_start: assert property (p_start) else $error("control value");
   property p_boot;
      cyc && stb && we && adr[7:0] == flash_row_pkg::OFS_BOOTPROT
         |-> datW == flash_row_pkg::BOOT_UNPROT
             && adr[31:8] == flash_row_pkg::BASE_GROUP_B[31:8];
   endproperty
   a_boot: assert property (p_boot) else $error("boot write");
   property p_base;
      cyc && stb |-> adr[31:8] == flash_row_pkg::BASE_GROUP_A[31:8]
                     || adr[31:8] == flash_row_pkg::BASE_GROUP_B[31:8];
   endproperty
   a_base: assert property (p_base) else $error("base");
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ****
   // Signals
   // ****
   logic        clk;
   logic        rst;
   logic        go;
   logic [31:0] rowAddr;
   logic [31:0] ramAddr;
   logic        busy;
   logic        done;
   logic        grp [2];
   logic        eM [2];
   logic        eG [2];
   logic        fBusy [2];
   logic [31:0] fAddr [2];
   logic [31:0] sAddr [2];
   logic [3:0]  fOp [2];
   logic        ecc [2];
   logic        wDone [2];
   logic        aErr [2];
   logic [31:0] q;
   logic [31:0] tgt;
   int          n;
   int          n_mismatch;
   int          tests_run;
   flash_row_if bI [2] ();
   // ****
   // Ends
   // ****
   for (genvar k = 0; k < 2; k++) begin : g_dev
      flash_row_device i_flash_row_device (
         .clk(clk), .rst(rst), .groupB(grp[k]), .execMode(eM[k]), .execGo(eG[k]),
         .bus(bI[k]), .flashBusy(fBusy[k]), .flashAddr(fAddr[k]), .sramAddr(sAddr[k]),
         .flashOp(fOp[k]), .eccStore(ecc[k]), .writeDone(wDone[k]), .alignErr(aErr[k]));
   end
   flash_row_host i_flash_row_host (
      .clk(clk), .rst(rst), .go(go), .groupB(grp[0]), .rowAddr(rowAddr),
      .ramAddr(ramAddr), .busy(busy), .done(done), .bus(bI[0]));
   flash_row_monitor u_mon (
      .clk(clk), .rst(rst), .adr(bI[0].adr), .datW(bI[0].datW), .cyc(bI[0].cyc),
      .stb(bI[0].stb), .we(bI[0].we), .ack(bI[0].ack));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // ****
   // Tasks
   // ****
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (!ok) begin
         n_mismatch++;
         $display("mismatch %0t %s", $time, m);
      end
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic wb(input logic [7:0] o, input logic w, input logic [31:0] d);
      int t;
      t = 0;
      bI[1].cyc <= 1'b1;
      bI[1].stb <= 1'b1;
      bI[1].we <= w;
      bI[1].adr <= (grp[1] ? flash_row_pkg::BASE_GROUP_B : flash_row_pkg::BASE_GROUP_A)
                   | {24'h000000, o};
      bI[1].datW <= d;
      do begin
         @(posedge clk);
         t++;
      end while (bI[1].ack !== 1'b1 && t < 20);
      q = bI[1].datR;
      bI[1].cyc <= 1'b0;
      bI[1].stb <= 1'b0;
      @(posedge clk);
      if (t >= 20) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask
   // Pulses are caught one edge late, so a single-cycle done is never missed
   task automatic wt(input int k);
      n = 0;
      while ((k == 0 ? done : wDone[1]) !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 2000) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask
   task automatic host(input logic g, input logic [31:0] r, input logic [31:0] s);
      grp[0] <= g;
      rowAddr <= r;
      ramAddr <= s;
      repeat (2) @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wt(0);
      // Host leaves its gap state one edge after done
      @(posedge clk);
      chk(fAddr[0] === r && sAddr[0] === s, "host addresses");
      chk(fOp[0] === flash_row_pkg::OP_ROW && ecc[0] === 1'b1, "host op");
      chk(aErr[0] === (r[3:0] != 4'h0), "host align");
      chk(fBusy[0] === 1'b0 && busy === 1'b0, "host idle");
   endtask
   // ****
   // Sequence
   // ****
   initial begin
      rst = 1'b1;
      go = 1'b0;
      rowAddr = 32'h0;
      ramAddr = 32'h0;
      grp = '{1'b0, 1'b0};
      eM = '{1'b0, 1'b0};
      eG = '{1'b0, 1'b0};
      bI[1].cyc = 1'b0;
      bI[1].stb = 1'b0;
      bI[1].we = 1'b0;
      bI[1].adr = 32'h0;
      bI[1].datW = 32'h0;
      bI[1].sel = 4'hF;
      n_mismatch = 0;
      tests_run = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      host(1'b0, 32'h1D00_0800, 32'h0000_0400);
      host(1'b1, 32'h1D00_1004, 32'h0000_0800);
      wb(8'h04, 1'b0, 32'h0);
      chk(q === 32'h0, "unmapped read");
      wb(flash_row_pkg::OFS_CONTROL, 1'b1, flash_row_pkg::CTRL_ROW_SEL);
      wb(flash_row_pkg::OFS_CONTROL, 1'b1, flash_row_pkg::CTRL_START);
      chk(fBusy[1] === 1'b0, "start while locked");
      for (int op = 1; op < 4; op++) begin
         tgt = 32'h1D00_2000 | (op == 3 ? 32'h4 : 32'h0);
         wb(flash_row_pkg::OFS_TARGET, 1'b1, tgt);
         wb(flash_row_pkg::OFS_SOURCE, 1'b1, 32'h0000_0100 * op);
         wb(flash_row_pkg::OFS_CONTROL, 1'b1, 32'h0000_4000 | op);
         wb(flash_row_pkg::OFS_KEY, 1'b1, flash_row_pkg::KEY_FIRST);
         wb(flash_row_pkg::OFS_KEY, 1'b1, flash_row_pkg::KEY_SECOND);
         wb(flash_row_pkg::OFS_CONTROL, 1'b1, flash_row_pkg::CTRL_START);
         wb(flash_row_pkg::OFS_CONTROL, 1'b0, 32'h0);
         chk(q[15] === 1'b1 && fBusy[1] === 1'b1, "start");
         wb(flash_row_pkg::OFS_STATUS, 1'b0, 32'h0);
         chk(q === {28'h0, (op == 3), 3'b001}, "status");
         // Refused while the write runs, so the target must survive
         wb(flash_row_pkg::OFS_TARGET, 1'b1, 32'hFFFF_FFF0);
         chk(fOp[1] === 4'(op) && ecc[1] === (op != 1), "check bits");
         chk(aErr[1] === (op == 3), "align");
         chk(sAddr[1] === 32'h0000_0100 * op, "source");
         wt(1);
         wb(flash_row_pkg::OFS_CONTROL, 1'b0, 32'h0);
         chk(q[15] === 1'b0, "start self clear");
         wb(flash_row_pkg::OFS_TARGET, 1'b0, 32'h0);
         chk(q === tgt, "target");
         chk(fAddr[1] === tgt, "flash address");
      end
      grp[1] <= 1'b1;
      repeat (2) @(posedge clk);
      wb(flash_row_pkg::OFS_KEY, 1'b1, flash_row_pkg::KEY_FIRST);
      wb(flash_row_pkg::OFS_KEY, 1'b1, flash_row_pkg::KEY_SECOND);
      wb(flash_row_pkg::OFS_BOOTPROT, 1'b1, 32'h0000_8081);
      wb(flash_row_pkg::OFS_BOOTPROT, 1'b0, 32'h0);
      chk(q === 32'h0000_0001, "boot protect");
      eM[1] <= 1'b1;
      eG[1] <= 1'b1;
      @(posedge clk);
      eG[1] <= 1'b0;
      repeat (2) @(posedge clk);
      chk(fBusy[1] === 1'b1 && fOp[1] === flash_row_pkg::OP_ROW, "exec start");
      chk(ecc[1] === 1'b1, "exec check bits");
      wt(1);
      report_and_stop();
   end
endmodule
